// ---- core/wwd_core.v ----
// Window watchdog with APB register access.
// Assumes pclk is the divided oscillator clock; option and halt inputs
// arrive from other clock domains and are synchronised here.
`default_nettype none
`include "wwd_defs.vh"

module wwd_core #(
    parameter PRESCALE = `WWD_PRESCALE,
    parameter PULSE_CYC = `WWD_PULSE_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire pclken,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire hw_activation,
    input wire halt_reset_option,
    input wire oscillator_irq_enable,
    input wire halt_req,
    input wire wakeup,
    output wire reset_pin_n,
    output reg wdg_reset_ff
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg [4:0] sync1_ff;
    reg [4:0] sync2_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
        end else if (pclken) begin
            sync1_ff <= {wakeup, halt_req, oscillator_irq_enable,
                         halt_reset_option, hw_activation};
            sync2_ff <= sync1_ff;
        end
    end

    wire hw_act = sync2_ff[0];
    wire halt_opt = sync2_ff[1];
    wire osc_ie = sync2_ff[2];
    wire halt_s = sync2_ff[3];
    wire wake_s = sync2_ff[4];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg [6:0] cnt_ff;
    reg [6:0] nxt_cnt;
    reg [6:0] win_ff;
    reg act_ff;
    reg frozen_ff;
    reg halt_d_ff;
    reg [13:0] pre_ff;
    reg fault_ff;

    wire active = act_ff | hw_act;
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire wr_ctrl = wr & (paddr == `WWD_CTRL_OFFSET);
    wire wr_win = wr & (paddr == `WWD_WIN_OFFSET);
    wire mapped = (paddr == `WWD_CTRL_OFFSET) | (paddr == `WWD_WIN_OFFSET) |
                  (paddr == `WWD_STAT_OFFSET);
    wire pre_wrap = (pre_ff == PRESCALE[13:0] - 14'h0001);
    wire halt_edge = halt_s & ~halt_d_ff;
    wire tick = pre_wrap & ~frozen_ff;

    // ------------------------------------------------------------------
    // Prescaler: never cleared by control writes, so timeouts vary by
    // up to one step depending on where the write lands.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 14'h0000;
        end else if (pclken && !frozen_ff) begin
            pre_ff <= pre_wrap ? 14'h0000 : pre_ff + 14'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Counter and reset decisions
    // ------------------------------------------------------------------
    reg new_act;
    reg trig;

    always @* begin
        nxt_cnt = cnt_ff;
        new_act = act_ff;
        trig = 1'b0;
        if (tick) begin
            nxt_cnt = cnt_ff - 7'h01;
            if (active && cnt_ff == 7'h40) begin
                trig = 1'b1;
            end
        end
        if (wr_ctrl) begin
            // Window check uses the value before the load.
            if (active && cnt_ff > win_ff) begin
                trig = 1'b1;
            end
            nxt_cnt = pwdata[6:0];
            if (pwdata[`WWD_ACT_BIT]) begin
                new_act = 1'b1;
            end
            if ((pwdata[`WWD_ACT_BIT] || active) && !pwdata[`WWD_TOP_BIT]) begin
                trig = 1'b1;
            end
        end
        if (halt_edge && active && !osc_ie && halt_opt) begin
            trig = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= `WWD_CTRL_RST;
            win_ff <= `WWD_WIN_RST;
            act_ff <= 1'b0;
            frozen_ff <= 1'b0;
            halt_d_ff <= 1'b0;
            fault_ff <= 1'b0;
            wdg_reset_ff <= 1'b0;
        end else if (pclken) begin
            cnt_ff <= nxt_cnt;
            act_ff <= new_act;
            halt_d_ff <= halt_s;
            wdg_reset_ff <= trig;
            if (trig) begin
                fault_ff <= 1'b1;
            end
            if (wr_win) begin
                win_ff <= pwdata[6:0];
            end
            // Active-halt holds the counter until a wakeup arrives.
            if (halt_edge && osc_ie) begin
                frozen_ff <= 1'b1;
            end else if (wake_s) begin
                frozen_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, so pready rises in the access phase.
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (pclken) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `WWD_CTRL_OFFSET: prdata <= {24'h000000, active, cnt_ff};
                    `WWD_WIN_OFFSET: prdata <= {25'h0000000, win_ff};
                    `WWD_STAT_OFFSET: prdata <= {29'h00000000, frozen_ff, fault_ff,
                                                 hw_act};
                    default: prdata <= 32'h00000000;
                endcase
            end else if (rd) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset pin stretcher
    // ------------------------------------------------------------------
    wwd_pulse #(
        .CYCLES(PULSE_CYC)
    ) u_pulse (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclken),
        .trig(wdg_reset_ff),
        .pin_n_ff(reset_pin_n)
    );

endmodule

`default_nettype wire

// ---- core/wwd_defs.vh ----
// Constants for the window watchdog: register offsets, field positions,
// reset values and timing counts. Assumes a 10 MHz APB clock.
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define WWD_CTRL_OFFSET 12'h000
`define WWD_WIN_OFFSET 12'h004
`define WWD_STAT_OFFSET 12'h008

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define WWD_ACT_BIT 7
`define WWD_TOP_BIT 6
`define WWD_CTRL_RST 7'h7F
`define WWD_WIN_RST 7'h7F
`define WWD_FLOOR 7'h3F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WWD_PRESCALE 16384
`define WWD_PULSE_NS 30000
`define WWD_CLK_NS 100
`define WWD_PULSE_CYC ((`WWD_PULSE_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)

`endif

// ---- core/wwd_pulse.v ----
// Reset pulse stretcher: turns a one-cycle trigger into a low pulse.
// Assumes the trigger is synchronous to clk.
`default_nettype none

module wwd_pulse #(
    parameter CYCLES = 300
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire trig,
    output reg pin_n_ff
);
    reg [15:0] cnt_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 16'h0000;
            pin_n_ff <= 1'b1;
        end else if (ce) begin
            if (trig) begin
                cnt_ff <= CYCLES[15:0] - 16'h0001;
                pin_n_ff <= 1'b0;
            end else if (cnt_ff != 16'h0000) begin
                cnt_ff <= cnt_ff - 16'h0001;
            end else begin
                pin_n_ff <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the window watchdog core over APB.
// Assumes short prescale and pulse counts set at the instance.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 16;
    localparam int W = 5;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, got;
    logic hw_activation = 0, halt_reset_option = 0, oscillator_irq_enable = 0;
    logic halt_req = 0, wakeup = 0, pready, pslverr, reset_pin_n, wdg_reset_ff;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    int errors = 0, n_compared = 0;
    always #50 pclk = ~pclk;
    wwd_core #(.PRESCALE(P), .PULSE_CYC(W)) dut (.pclk(pclk), .presetn(presetn),
        .pclken(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_activation(hw_activation), .halt_reset_option(halt_reset_option),
        .oscillator_irq_enable(oscillator_irq_enable), .halt_req(halt_req),
        .wakeup(wakeup), .reset_pin_n(reset_pin_n), .wdg_reset_ff(wdg_reset_ff));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rst;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    // Waits up to hi cycles; a reset pulse earlier than lo counts as absent.
    task automatic exp_rst(input int lo, input int hi, input logic e);
        got = 1'b0;
        for (int n = 0; n < hi && !got; n++) begin
            @(posedge pclk);
            got = (wdg_reset_ff === 1'b1) && n >= lo;
        end
        check(got, e);
        repeat (W + 3) @(posedge pclk);
    endtask
    task automatic close_out;
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge pclk);
        errors++;
        close_out;
    end
    initial begin
        rst;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0000007F);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0000007F);
        apb(1'b1, 12'h00C, 32'hFF);
        check(err, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h00000000);
        exp_rst(0, 70 * P, 0);
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7:0] inside {8'h38, 8'h39}, 1'b1);
        rst;
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b1, 12'h000, 32'h7F);
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7], 1'b1);
        apb(1'b1, 12'h000, 32'hC3);
        exp_rst(3 * P, 4 * P + 3, 1);
        rst;
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b1, 12'h004, 32'h78);
        apb(1'b1, 12'h000, 32'hFF);
        exp_rst(0, 3, 1);
        rst;
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b1, 12'h004, 32'h78);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h00000078);
        repeat (10 * P) @(posedge pclk);
        apb(1'b1, 12'h000, 32'hFF);
        exp_rst(0, 3, 0);
        apb(1'b1, 12'h000, 32'hFF);
        exp_rst(0, 3, 1);
        rst;
        apb(1'b1, 12'h000, 32'hBF);
        exp_rst(0, 3, 1);
        hw_activation <= 1'b1;
        halt_reset_option <= 1'b1;
        rst;
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7], 1'b1);
        apb(1'b1, 12'h000, 32'h41);
        exp_rst(P, 2 * P + 3, 1);
        rst;
        halt_req <= 1'b1;
        exp_rst(0, 8, 1);
        halt_req <= 1'b0;
        oscillator_irq_enable <= 1'b1;
        rst;
        apb(1'b1, 12'h000, 32'hC1);
        halt_req <= 1'b1;
        exp_rst(0, 4 * P, 0);
        apb(1'b0, 12'h008, 32'h0);
        check(rd[2], 1'b1);
        wakeup <= 1'b1;
        exp_rst(0, 2 * P + 6, 1);
        close_out;
    end
endmodule
`default_nettype wire

// ---- sim/wwd_props.sv ----
// Port checker for the window watchdog core.
// Assumes pclken is held high by the bench, so every clock counts.
`default_nettype none
module wwd_props #(parameter int PULSE_CYC = 300) (
    input wire pclk,
    input wire presetn,
    input wire pclken,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire hw_activation,
    input wire halt_reset_option,
    input wire oscillator_irq_enable,
    input wire halt_req,
    input wire reset_pin_n,
    input wire wdg_reset_ff
);
    logic [15:0] low_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_ff <= 16'h0000;
        else
            low_ff <= reset_pin_n ? 16'h0000 : low_ff + 16'h0001;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property (psel && penable && pclken && !pready && !$past(penable)
        |=> pready) else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_map_err: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
        12'h008})) else $error("pslverr wrong for address");
    chk_err_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read not zero");
    chk_pulse_start: assert property (wdg_reset_ff |=> !reset_pin_n)
        else $error("reset pin not driven low");
    chk_pulse_len: assert property ($rose(reset_pin_n) |-> low_ff == PULSE_CYC)
        else $error("reset pulse length wrong");
    chk_soft_reset: assert property (psel && penable && pready && pwrite && paddr == 12'h000
        && pwdata[7] && !pwdata[6] |=> wdg_reset_ff) else $error("no software reset");
    chk_hw_active: assert property (pready && !pwrite && paddr == 12'h000 && hw_activation
        && $past(hw_activation, 4) |-> prdata[7]) else $error("hardware watchdog inactive");
    chk_halt_reset: assert property ($rose(halt_req) && hw_activation && halt_reset_option
        && !oscillator_irq_enable |-> ##[1:8] wdg_reset_ff) else $error("no reset on halt");
endmodule
bind wwd_core wwd_props #(.PULSE_CYC(PULSE_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_activation(hw_activation), .halt_reset_option(halt_reset_option),
    .oscillator_irq_enable(oscillator_irq_enable), .halt_req(halt_req),
    .reset_pin_n(reset_pin_n), .wdg_reset_ff(wdg_reset_ff));
`default_nettype wire
